// ==== rtl/mtv_pkg.sv ====
package mtv_pkg;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 32;
  // register numbers; the plain port addresses registers directly
  localparam logic [15:0] REG_RB_LOW      = 16'h1805;
  localparam logic [15:0] REG_RB_HIGH     = 16'h1806;
  localparam logic [15:0] REG_CMD_STS     = 16'h1808;
  localparam logic [15:0] REG_AGE_CFG     = 16'h1809;
  localparam logic [15:0] REG_VLAN_CMD    = 16'h180B;
  localparam logic [15:0] REG_VLAN_WR     = 16'h180C;
  localparam logic [15:0] REG_VLAN_STS    = 16'h1810;
  localparam logic [15:0] REG_VLAN_RD     = 16'h1811;
  localparam logic [15:0] REG_IRQ_STS     = 16'h1812;
  localparam logic [15:0] REG_IRQ_MASK    = 16'h1813;
  // readback high word fields
  localparam int unsigned RB_VALID_BIT    = 26;
  localparam int unsigned RB_EOT_BIT      = 25;
  localparam int unsigned RB_STATIC_BIT   = 24;
  localparam int unsigned RB_FILTER_BIT   = 23;
  localparam int unsigned RB_PRIO_EN_BIT  = 22;
  localparam int unsigned RB_PRIO_LSB     = 19;
  localparam int unsigned RB_PORT_LSB     = 16;
  localparam int unsigned RB_MULTI_BIT    = 18;
  localparam int unsigned RB_MAC_HI_W     = 16;
  // command status and aging config
  localparam int unsigned MAKE_PEND_BIT   = 0;
  localparam int unsigned INIT_DONE_BIT   = 1;
  localparam int unsigned AGE_TEST_BIT    = 0;
  // vlan command fields
  localparam int unsigned VLAN_ACCESS_DIRECTION_BIT    = 5;
  localparam int unsigned VLAN_PVID_BIT   = 4;
  localparam int unsigned VLAN_IDX_W      = 4;
  localparam int unsigned VLAN_CMD_W      = 6;
  localparam int unsigned VLAN_PEND_BIT   = 0;
  localparam int unsigned VLAN_ENTRIES    = 16;
  localparam int unsigned PVID_PORTS      = 3;
  localparam int unsigned VLAN_DATA_W     = 18;
  localparam int unsigned PVID_DATA_W     = 15;
  localparam logic [14:0] PVID_RESET      = 15'h0001;
  localparam logic [17:0] VLAN_RESET      = 18'h00000;
  // interrupt status bits
  localparam int unsigned IRQ_INIT_BIT    = 0;
  localparam int unsigned IRQ_MAKE_BIT    = 1;
  localparam int unsigned IRQ_VLAN_BIT    = 2;
  localparam int unsigned IRQ_RB_BIT      = 3;
  localparam int unsigned IRQ_W           = 4;
  // timing
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned INIT_TIME_US    = 20;
  localparam int unsigned INIT_CYCLES     = INIT_TIME_US * CLK_MHZ;
  localparam int unsigned AGE_NORMAL_MIN  = 5;
  localparam int unsigned AGE_TEST_MS     = 50;
  localparam int unsigned AGE_NORMAL_MS   = AGE_NORMAL_MIN * 60 * 1000;
  localparam int unsigned MS_CYCLES       = 1000 * CLK_MHZ;
  localparam int unsigned VLAN_ACC_CYC    = 2;

  typedef enum logic [1:0] {
    VS_IDLE = 2'b00,
    VS_BUSY = 2'b01,
    VS_DONE = 2'b11
  } mtv_vstate_e;
endpackage : mtv_pkg

// ==== rtl/mtv_mac_table_vlan_access.sv ====
// What this block does
// - port field codes 000..111 name port 0,1,2, reserved, pairs, all.
// - port field top bit clear for one port, set for several.
// - second word bits 15:0 hold last address bits, bit 15 last on wire.
// - init-done reads zero after reset, sets when table init finishes.
// - table init after reset lasts about twenty microseconds.
// - every received packet is dropped while the table initialises.
// - make-pending bit is one during entry creation, cleared on finish.
// - aging-test bit shortens aging period from five minutes to 50 ms.
// - a vlan command register write launches a table access only when idle; one written while pending is dropped.
// - command bit 5 one requests read, zero requests write.
// - command bit 4 one selects default-vid table, zero vlan table.
// - index names vlan 0-15 or port 0-2; others are undefined.
// - pending bit holds until a read ends; read data read after.
// - readback words valid only when valid or end-of-table flag set.
// - non-static entries age out after five to ten idle minutes.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module mtv_mac_table_vlan_access
  import mtv_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES   = MS_CYCLES,
  parameter int unsigned AGE_NORMAL_TICKS = AGE_NORMAL_MS,
  parameter int unsigned AGE_TEST_TICKS   = AGE_TEST_MS,
  parameter int unsigned VLAN_ACCESS_CYC  = VLAN_ACC_CYC
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic              rbClear,
  input  wire logic              rbLoad,
  input  wire logic [47:0]       rbMac,
  input  wire logic [2:0]        rbPortMask,
  input  wire logic              rbValid,
  input  wire logic              rbEndOfTable,
  input  wire logic              rbStatic,
  input  wire logic              rbFilter,
  input  wire logic              rbPrioEn,
  input  wire logic [2:0]        rbPrio,
  input  wire logic              makeStart,
  input  wire logic              makeDone,
  output logic                   initBusy,
  output logic                   packetDrop,
  output logic                   ageTick,
  output logic                   irq
);

  localparam int unsigned INIT_CNT_W = $clog2(INIT_CYCLES + 1);
  localparam int unsigned MS_CNT_W   = $clog2(MS_TICK_CYCLES + 1);
  localparam int unsigned AGE_CNT_W  = $clog2(AGE_NORMAL_TICKS + 1);
  localparam int unsigned VACC_CNT_W = $clog2(VLAN_ACCESS_CYC + 1);

  generate
    if (MS_TICK_CYCLES < 1 || AGE_TEST_TICKS < 1 || VLAN_ACCESS_CYC < 1 ||
        AGE_TEST_TICKS > AGE_NORMAL_TICKS) begin : g_bad_param
      $error("mtv_mac_table_vlan_access: unusable parameter values");
    end
  endgenerate

  // port membership mask to readback port code
  function automatic logic [2:0] portCode(input logic [2:0] mask);
    logic [2:0] code;
    code = 3'h0;
    unique case (mask)
      3'b001:  code = 3'h0;
      3'b010:  code = 3'h1;
      3'b100:  code = 3'h2;
      3'b011:  code = 3'h4;
      3'b101:  code = 3'h5;
      3'b110:  code = 3'h6;
      3'b111:  code = 3'h7;
      default: code = 3'h0;
    endcase
    return code;
  endfunction : portCode

  logic [INIT_CNT_W-1:0]  initCnt;
  logic                   initDone;
  logic                   makePending;
  logic                   ageTest;
  logic [MS_CNT_W-1:0]    msCnt;
  logic                   msTick;
  logic [AGE_CNT_W-1:0]   ageCnt;
  logic [31:0]            rbLow;
  logic [RB_MAC_HI_W-1:0] rbMacHi;
  logic [2:0]             rbPort;
  logic                   rbValidFlag;
  logic                   rbEotFlag;
  logic                   rbStaticFlag;
  logic                   rbFilterFlag;
  logic                   rbPrioEnFlag;
  logic [2:0]             rbPrioField;
  logic [VLAN_CMD_W-1:0]  vlanCmd;
  logic [VLAN_DATA_W-1:0] vlanWrWord;
  logic [VLAN_DATA_W-1:0] vlanRdWord;
  logic [VLAN_DATA_W-1:0] vlanMem [VLAN_ENTRIES];
  logic [PVID_DATA_W-1:0] pvidMem [PVID_PORTS];
  mtv_vstate_e            vState;
  mtv_vstate_e            next_vState;
  logic [VACC_CNT_W-1:0]  vCnt;
  logic [IRQ_W-1:0]       irqSts;
  logic [IRQ_W-1:0]       irqMask;
  logic [IRQ_W-1:0]       irqEvent;
  logic [DATA_W-1:0]      next_regRdData;
  logic                   vlanCmdWr;
  logic                   initFinish;
  logic                   vAccess;
  logic [VLAN_IDX_W-1:0]  vIdx;
  logic [31:0]            rbHigh;

  assign vlanCmdWr  = regWr && regAddr == REG_VLAN_CMD && vState == VS_IDLE;
  assign initFinish = !initDone &&
                      initCnt == INIT_CNT_W'(INIT_CYCLES - 1);
  assign vAccess    = vState == VS_DONE;
  assign vIdx       = vlanCmd[VLAN_IDX_W-1:0];

  // table init timer after every fabric reset
  always_ff @(posedge clk) begin
    if (srst) begin
      initCnt  <= '0;
      initDone <= 1'b0;
    end else if (!initDone) begin
      initCnt  <= initCnt + INIT_CNT_W'(1);
      initDone <= initFinish;
    end
  end

  assign initBusy   = !initDone;
  assign packetDrop = !initDone;

  // start wins over done so a fresh command is never missed
  always_ff @(posedge clk) begin
    if (srst) begin
      makePending <= 1'b0;
    end else if (makeStart) begin
      makePending <= 1'b1;
    end else if (makeDone) begin
      makePending <= 1'b0;
    end
  end

  // millisecond prescaler shared by both aging periods
  always_ff @(posedge clk) begin
    if (srst) begin
      msCnt  <= '0;
      msTick <= 1'b0;
    end else begin
      msTick <= msCnt == MS_CNT_W'(MS_TICK_CYCLES - 1);
      if (msCnt == MS_CNT_W'(MS_TICK_CYCLES - 1)) begin
        msCnt <= '0;
      end else begin
        msCnt <= msCnt + MS_CNT_W'(1);
      end
    end
  end

  // an entry idle across two ticks is removed, giving five to ten minutes
  always_ff @(posedge clk) begin
    if (srst) begin
      ageCnt  <= '0;
      ageTick <= 1'b0;
    end else begin
      ageTick <= 1'b0;
      if (msTick) begin
        if ((ageTest && ageCnt >= AGE_CNT_W'(AGE_TEST_TICKS - 1)) ||
            ageCnt >= AGE_CNT_W'(AGE_NORMAL_TICKS - 1)) begin
          ageCnt  <= '0;
          ageTick <= 1'b1;
        end else begin
          ageCnt <= ageCnt + AGE_CNT_W'(1);
        end
      end
    end
  end

  // readback words, loaded by the table walker
  always_ff @(posedge clk) begin
    if (srst) begin
      rbLow        <= 32'h0000_0000;
      rbMacHi      <= 16'h0000;
      rbPort       <= 3'h0;
      rbValidFlag  <= 1'b0;
      rbEotFlag    <= 1'b0;
      rbStaticFlag <= 1'b0;
      rbFilterFlag <= 1'b0;
      rbPrioEnFlag <= 1'b0;
      rbPrioField  <= 3'h0;
    end else if (rbLoad) begin
      rbLow        <= rbMac[31:0];
      rbMacHi      <= rbMac[47:32];
      rbPort       <= portCode(rbPortMask);
      rbValidFlag  <= rbValid;
      rbEotFlag    <= rbEndOfTable;
      rbStaticFlag <= rbStatic;
      rbFilterFlag <= rbFilter;
      rbPrioEnFlag <= rbPrioEn;
      rbPrioField  <= rbPrio;
    end else if (rbClear) begin
      rbValidFlag <= 1'b0;
      rbEotFlag   <= 1'b0;
    end
  end

  always_comb begin
    rbHigh                           = 32'h0000_0000;
    rbHigh[RB_MAC_HI_W-1:0]          = rbMacHi;
    rbHigh[RB_PORT_LSB +: 3]         = rbPort;
    rbHigh[RB_PRIO_LSB +: 3]         = rbPrioField;
    rbHigh[RB_PRIO_EN_BIT]           = rbPrioEnFlag;
    rbHigh[RB_FILTER_BIT]            = rbFilterFlag;
    rbHigh[RB_STATIC_BIT]            = rbStaticFlag;
    rbHigh[RB_EOT_BIT]               = rbEotFlag;
    rbHigh[RB_VALID_BIT]             = rbValidFlag;
  end

  // software configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ageTest    <= 1'b0;
      vlanCmd    <= '0;
      vlanWrWord <= '0;
      irqMask    <= '0;
    end else if (regWr) begin
      if (regAddr == REG_AGE_CFG) begin
        ageTest <= regWrData[AGE_TEST_BIT];
      end
      // a command written while busy is dropped whole
      if (vlanCmdWr) begin
        vlanCmd <= regWrData[VLAN_CMD_W-1:0];
      end
      if (regAddr == REG_VLAN_WR) begin
        vlanWrWord <= regWrData[VLAN_DATA_W-1:0];
      end
      if (regAddr == REG_IRQ_MASK) begin
        irqMask <= regWrData[IRQ_W-1:0];
      end
    end
  end

  // vlan access sequencer
  always_comb begin
    next_vState = vState;
    unique case (vState)
      VS_IDLE: if (vlanCmdWr) next_vState = VS_BUSY;
      VS_BUSY: if (vCnt == VACC_CNT_W'(VLAN_ACCESS_CYC - 1)) begin
        next_vState = VS_DONE;
      end
      VS_DONE: next_vState = VS_IDLE;
      default: next_vState = VS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vState <= VS_IDLE;
      vCnt   <= '0;
    end else begin
      vState <= next_vState;
      vCnt   <= (vState == VS_BUSY) ? vCnt + VACC_CNT_W'(1) : '0;
    end
  end

  // out-of-range port index: write ignored, read returns zero
  always_ff @(posedge clk) begin
    if (srst) begin
      vlanRdWord <= '0;
      for (int i = 0; i < VLAN_ENTRIES; i++) begin
        vlanMem[i] <= VLAN_RESET;
      end
      for (int i = 0; i < PVID_PORTS; i++) begin
        pvidMem[i] <= PVID_RESET;
      end
    end else if (vAccess) begin
      if (vlanCmd[VLAN_ACCESS_DIRECTION_BIT]) begin
        if (!vlanCmd[VLAN_PVID_BIT]) begin
          vlanRdWord <= vlanMem[vIdx];
        end else if (vIdx < VLAN_IDX_W'(PVID_PORTS)) begin
          vlanRdWord <= VLAN_DATA_W'(pvidMem[vIdx[1:0]]);
        end else begin
          vlanRdWord <= '0;
        end
      end else if (!vlanCmd[VLAN_PVID_BIT]) begin
        vlanMem[vIdx] <= vlanWrWord;
      end else if (vIdx < VLAN_IDX_W'(PVID_PORTS)) begin
        pvidMem[vIdx[1:0]] <= vlanWrWord[PVID_DATA_W-1:0];
      end
    end
  end

  // sticky event flags; a set in the clearing read cycle survives
  assign irqEvent[IRQ_INIT_BIT] = initFinish;
  assign irqEvent[IRQ_MAKE_BIT] = makePending && makeDone && !makeStart;
  assign irqEvent[IRQ_VLAN_BIT] = vAccess;
  assign irqEvent[IRQ_RB_BIT]   = rbLoad;

  always_ff @(posedge clk) begin
    if (srst) begin
      irqSts <= '0;
    end else if (regRd && regAddr == REG_IRQ_STS) begin
      irqSts <= irqEvent;
    end else begin
      irqSts <= irqSts | irqEvent;
    end
  end

  assign irq = |(irqSts & irqMask);

  // read mux; unmapped addresses read zero
  always_comb begin
    next_regRdData = '0;
    unique case (regAddr)
      REG_RB_LOW:   next_regRdData = rbLow;
      REG_RB_HIGH:  next_regRdData = rbHigh;
      REG_CMD_STS: begin
        next_regRdData[INIT_DONE_BIT] = initDone;
        next_regRdData[MAKE_PEND_BIT] = makePending;
      end
      REG_AGE_CFG:  next_regRdData[AGE_TEST_BIT] = ageTest;
      REG_VLAN_CMD: next_regRdData[VLAN_CMD_W-1:0] = vlanCmd;
      REG_VLAN_WR:  next_regRdData[VLAN_DATA_W-1:0] = vlanWrWord;
      REG_VLAN_STS: next_regRdData[VLAN_PEND_BIT] =
                      vState != VS_IDLE;
      REG_VLAN_RD:  next_regRdData[VLAN_DATA_W-1:0] = vlanRdWord;
      REG_IRQ_STS:  next_regRdData[IRQ_W-1:0] = irqSts;
      REG_IRQ_MASK: next_regRdData[IRQ_W-1:0] = irqMask;
      default:      next_regRdData = '0;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRd ? next_regRdData : '0;
    end
  end

endmodule : mtv_mac_table_vlan_access

// ==== verif/mtv_mac_table_vlan_access_properties.sv ====
`timescale 1ns/1ns
module mtv_props
  import mtv_pkg::*;
#(
  parameter int unsigned VLAN_ACCESS_CYC = VLAN_ACC_CYC
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic              rbLoad,
  input wire logic [47:0]       rbMac,
  input wire logic              makeStart,
  input wire logic              makeDone,
  input wire logic              initBusy,
  input wire logic              packetDrop,
  input wire logic              ageTick
);
  logic [11:0] upCnt;
  logic [3:0]  vCnt;
  logic        stsRd;
  assign stsRd = regRd && regAddr == REG_CMD_STS;
  always_ff @(posedge clk) begin
    if (srst) upCnt <= 12'h000;
    else if (upCnt != 12'hFFF) upCnt <= upCnt + 12'h001;
  end
  // refused writes must not restart the modelled pending window
  always_ff @(posedge clk) begin
    if (srst) vCnt <= 4'h0;
    else if (regWr && regAddr == REG_VLAN_CMD && vCnt == 4'h0)
      vCnt <= 4'(VLAN_ACCESS_CYC + 1);
    else if (vCnt != 4'h0) vCnt <= vCnt - 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_drop_while_init: assert property (
    packetDrop == initBusy) else $error("drop differs from init busy");
  a_init_busy_early: assert property (
    upCnt < 12'h9C3 |-> initBusy) else $error("init ended too early");
  a_init_done_late: assert property (
    upCnt > 12'h9C5 |-> !initBusy) else $error("init still busy");
  a_done_bit_read: assert property (
    stsRd |=> regRdData[31:1] == {30'h0, !$past(initBusy)})
    else $error("init done bit wrong");
  a_make_sets_pend: assert property (
    makeStart ##1 stsRd |=> regRdData[0]) else $error("pending not set");
  a_make_clears_pend: assert property (
    (makeDone && !makeStart) ##1 stsRd |=> !regRdData[0])
    else $error("pending not cleared");
  a_vlan_pend_read: assert property (
    regRd && regAddr == REG_VLAN_STS |=>
    regRdData == {31'h0, $past(vCnt) != 4'h0})
    else $error("vlan pending bit wrong");
  a_age_tick_single: assert property (
    ageTick |=> !ageTick [*3]) else $error("aging tick too long");
  a_readback_low: assert property (
    rbLoad ##1 (regRd && regAddr == REG_RB_LOW) |=>
    regRdData == $past(rbMac[31:0], 2)) else $error("readback low wrong");
  a_port_code_legal: assert property (
    regRd && regAddr == REG_RB_HIGH |=>
    regRdData[18:16] != 3'h3 && regRdData[31:27] == 5'h00)
    else $error("readback high code or reserved bits wrong");
  cover property ($fell(initBusy));
  cover property (ageTick);
  cover property (regWr && regAddr == REG_VLAN_CMD && vCnt == 4'h0);
endmodule : mtv_props

bind mtv_mac_table_vlan_access mtv_props #(
  .VLAN_ACCESS_CYC(VLAN_ACCESS_CYC)
) i_props (
  .clk, .srst, .regAddr, .regWr, .regRd, .regRdData, .rbLoad, .rbMac,
  .makeStart, .makeDone, .initBusy, .packetDrop, .ageTick
);

// ==== verif/mtv_mac_table_vlan_access_bench.sv ====
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failCount++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module mtv_mac_table_vlan_access_bench
  import mtv_pkg::*;
;
  localparam int unsigned MS = 4;
  localparam int unsigned AN = 20;
  localparam int unsigned AT = 5;
  localparam int unsigned VC = 2;
  localparam logic [2:0] PCODE [8] =
    '{3'h0, 3'h0, 3'h1, 3'h4, 3'h2, 3'h5, 3'h6, 3'h7};
  int          seed       = 96950;
  int          failCount  = 0;
  int          checks     = 0;
  logic        clk        = 1'b0;
  logic        srst       = 1'b1;
  logic [15:0] regAddr    = 16'h0000;
  logic [31:0] regWrData  = 32'h0;
  logic        regWr      = 1'b0;
  logic        regRd      = 1'b0;
  logic        rbClear    = 1'b0;
  logic        rbLoad     = 1'b0;
  logic [47:0] rbMac      = 48'h0;
  logic [2:0]  rbPortMask = 3'h0;
  logic [7:0]  rbFlags    = 8'h00;
  logic        makeStart  = 1'b0;
  logic        makeDone   = 1'b0;
  logic        rdSeen     = 1'b0;
  logic [31:0] regRdData;
  logic        initBusy, packetDrop, ageTick, irq;
  logic [31:0] expQ[$];
  logic [15:0] adrQ[$];
  logic [31:0] expV, d;
  logic [15:0] adrV;
  logic [47:0] mac;
  logic [31:0] vd[16];
  logic [31:0] pd[3];

  mtv_mac_table_vlan_access #(
    .MS_TICK_CYCLES(MS), .AGE_NORMAL_TICKS(AN), .AGE_TEST_TICKS(AT),
    .VLAN_ACCESS_CYC(VC)
  ) i_dut (
    .clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .rbClear, .rbLoad, .rbMac, .rbPortMask, .rbValid(rbFlags[7]),
    .rbEndOfTable(rbFlags[6]), .rbStatic(rbFlags[5]),
    .rbFilter(rbFlags[4]), .rbPrioEn(rbFlags[3]), .rbPrio(rbFlags[2:0]),
    .makeStart, .makeDone, .initBusy, .packetDrop, .ageTick, .irq
  );

  always #4 clk = ~clk;

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    regWr     <= 1'b1;
    regRd     <= 1'b0;
    regAddr   <= a;
    regWrData <= v;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] v);
    regRd   <= 1'b1;
    regWr   <= 1'b0;
    regAddr <= a;
    expQ.push_back(v);
    adrQ.push_back(a);
    @(posedge clk);
  endtask : rd

  task automatic idle(input int n);
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  // first tick after a config change may be short, so time the next one
  task automatic ageGap(input int exp);
    int n;
    idle(1);
    for (n = 0; n < 800 && ageTick !== 1'b1; n++) @(posedge clk);
    @(posedge clk);
    for (n = 1; n < 800 && ageTick !== 1'b1; n++) @(posedge clk);
    `CHK("age gap", exp, n)
  endtask : ageGap

  task automatic vAcc(input logic rnw, input logic pv,
                      input logic [3:0] ix, input logic [31:0] v);
    if (!rnw) wr(REG_VLAN_WR, v);
    wr(REG_VLAN_CMD, {26'h0, rnw, pv, ix});
    rd(REG_VLAN_STS, 32'h1);
    idle(VC);
    rd(REG_VLAN_STS, 32'h0);
    if (rnw) rd(REG_VLAN_RD, v);
  endtask : vAcc

  task automatic giveVerdict();
    if (failCount == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : giveVerdict

  always @(posedge clk) begin
    if (rdSeen) begin
      expV = expQ.pop_front();
      adrV = adrQ.pop_front();
      `CHK($sformatf("reg %h", adrV), expV, regRdData)
    end
    rdSeen <= regRd;
  end

  initial begin
    #(8 * 20000);
    failCount++;
    giveVerdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(REG_CMD_STS, 32'h0);
    rd(REG_AGE_CFG, 32'h0);
    rd(REG_RB_HIGH, 32'h0);
    rd(16'h1234, 32'h0);
    idle(1);
    `CHK("drop", 1'b1, packetDrop)
    for (int k = 0; k < 3000 && initBusy !== 1'b0; k++)
      @(posedge clk);
    `CHK("drop", 1'b0, packetDrop)
    rd(REG_CMD_STS, 32'h2);
    rd(REG_IRQ_STS, 32'h1);
    rd(REG_IRQ_STS, 32'h0);
    wr(REG_CMD_STS, 32'hFFFF_FFFF);
    rd(REG_CMD_STS, 32'h2);
    makeStart <= 1'b1;
    idle(1);
    makeStart <= 1'b0;
    rd(REG_CMD_STS, 32'h3);
    makeDone <= 1'b1;
    rd(REG_CMD_STS, 32'h3);
    makeDone <= 1'b0;
    rd(REG_CMD_STS, 32'h2);
    idle(2);
    `CHK("irq masked", 1'b0, irq)
    wr(REG_IRQ_MASK, 32'h2);
    idle(2);
    `CHK("irq", 1'b1, irq)
    rd(REG_IRQ_STS, 32'h2);
    idle(2);
    `CHK("irq cleared", 1'b0, irq)
    for (int i = 0; i < 8; i++) begin
      mac = 48'({$random(seed), $random(seed)});
      d = 32'($random(seed));
      rbMac <= mac;
      rbPortMask <= 3'(i);
      rbFlags <= d[7:0];
      rbLoad <= 1'b1;
      idle(1);
      rbLoad <= 1'b0;
      rd(REG_RB_LOW, mac[31:0]);
      rd(REG_RB_HIGH,
         {5'h0, d[7:0], PCODE[i], mac[47:32]});
    end
    rbClear <= 1'b1;
    idle(1);
    rbClear <= 1'b0;
    rd(REG_RB_HIGH, {7'h0, d[5:0], 3'h7, mac[47:32]});
    d = 32'($random(seed)) | 32'h1;
    wr(REG_AGE_CFG, d);
    rd(REG_AGE_CFG, 32'h1);
    ageGap(AT * MS);
    wr(REG_AGE_CFG, d & 32'hFFFF_FFFE);
    ageGap(AN * MS);
    vAcc(1'b1, 1'b1, 4'h0, 32'h1);
    for (int i = 0; i < 16; i++) begin
      vd[i] = 32'($random(seed));
      vAcc(1'b0, 1'b0, 4'(i), vd[i]);
    end
    for (int i = 0; i < 3; i++) begin
      pd[i] = 32'($random(seed));
      vAcc(1'b0, 1'b1, 4'(i), pd[i]);
    end
    rd(REG_VLAN_WR, pd[2] & 32'h3_FFFF);
    for (int i = 0; i < 16; i++)
      vAcc(1'b1, 1'b0, 4'(i), vd[i] & 32'h3_FFFF);
    for (int i = 0; i < 3; i++)
      vAcc(1'b1, 1'b1, 4'(i), pd[i] & 32'h7FFF);
    // second command lands while the first is pending and must be dropped
    wr(REG_VLAN_CMD, 32'hFFFF_FFE1);
    wr(REG_VLAN_CMD, 32'h0000_0002);
    idle(VC + 1);
    rd(REG_VLAN_CMD, 32'h21);
    rd(REG_VLAN_RD, vd[1] & 32'h3_FFFF);
    rd(REG_IRQ_STS, 32'hC);
    // fabric reset mid-run must restart table init
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    rd(REG_CMD_STS, 32'h0);
    rd(REG_VLAN_RD, 32'h0);
    `CHK("drop", 1'b1, packetDrop)
    idle(2);
    giveVerdict();
  end
endmodule : mtv_mac_table_vlan_access_bench
